// File: include/dsil_pkg.sv
/*
 Shared constants for the drive status indicator logic: state codes
 of the safety supervisor and the motion axis, register map, lamp
 patterns and flash timing.
 Assumes a 250 MHz system clock and 32-bit APB data.
*/
package dsil_pkg;

  localparam int CODE_W = 4;

  localparam logic [3:0] SUP_SELF_TEST   = 4'h0;
  localparam logic [3:0] SUP_TEST_EXC    = 4'h1;
  localparam logic [3:0] SUP_WAIT_ID     = 4'h2;
  localparam logic [3:0] SUP_CONFIG      = 4'h3;
  localparam logic [3:0] SUP_IDLE        = 4'h4;
  localparam logic [3:0] SUP_WAIT_ID_TRQ = 4'h5;
  localparam logic [3:0] SUP_EXEC        = 4'h6;
  localparam logic [3:0] SUP_EXEC_TRQ    = 4'h7;
  localparam logic [3:0] SUP_ABORT       = 4'h8;
  localparam logic [3:0] SUP_CRIT        = 4'h9;

  localparam logic [3:0] AX_INIT      = 4'h0;
  localparam logic [3:0] AX_PRECHARGE = 4'h1;
  localparam logic [3:0] AX_SHUTDOWN  = 4'h2;
  localparam logic [3:0] AX_START_INH = 4'h3;
  localparam logic [3:0] AX_STOPPED   = 4'h4;
  localparam logic [3:0] AX_STOPPING  = 4'h5;
  localparam logic [3:0] AX_STARTING  = 4'h6;
  localparam logic [3:0] AX_RUNNING   = 4'h7;
  localparam logic [3:0] AX_TESTING   = 4'h8;
  localparam logic [3:0] AX_ABORTING  = 4'h9;
  localparam logic [3:0] AX_MAJOR_FLT = 4'ha;
  localparam logic [3:0] AX_SELF_TEST = 4'hb;

  localparam int         ADDR_W        = 8;
  localparam logic [7:0] NET_CTRL_ADDR = 8'h00;
  localparam logic [7:0] ID_CMD_ADDR   = 8'h04;
  localparam logic [7:0] STATUS_ADDR   = 8'h08;

  localparam int NC_W        = 5;
  localparam int NC_ADDR_CFG = 0;
  localparam int NC_CONN     = 1;
  localparam int NC_OWNER_TO = 2;
  localparam int NC_CONFLICT = 3;
  localparam int NC_SELFTEST = 4;
  localparam logic [NC_W-1:0] NC_RESET = 5'h10;

  localparam int ID_PROPOSE = 0;
  localparam int ID_COMMIT  = 1;

  localparam int NPORTS_DEF = 2;

  localparam longint CLK_PERIOD_NS = 4;
  localparam longint SLOW_HALF_NS  = 500000000;
  localparam longint FAST_HALF_NS  = 125000000;
  localparam int SLOW_HALF_CYC = int'(SLOW_HALF_NS / CLK_PERIOD_NS);
  localparam int FAST_HALF_CYC = int'(FAST_HALF_NS / CLK_PERIOD_NS);
  localparam int FLASH_CNT_W   = 32;

  typedef enum logic [2:0] {
    PAT_OFF, PAT_GREEN, PAT_RED, PAT_FLASH_G, PAT_FLASH_R,
    PAT_ALT_SLOW, PAT_ALT_FAST
  } dsil_pat_t;

endpackage

// File: logic/dsil_flash.sv
/*
 Free-running flash phase generator with a slow and a fast rate.
 Assumes one clock domain and a clock enable that freezes it.
*/
`timescale 1ns/10ps
module dsil_flash
  import dsil_pkg::*;
#(
  parameter int SLOW_HALF = SLOW_HALF_CYC,
  parameter int FAST_HALF = FAST_HALF_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  output logic      slow_phase,
  output logic      fast_phase
);

  localparam int NR = 2;
  localparam logic [FLASH_CNT_W-1:0] HALF [NR] = '{
    FLASH_CNT_W'(SLOW_HALF - 1), FLASH_CNT_W'(FAST_HALF - 1)};

  typedef struct packed {
    logic [NR-1:0][FLASH_CNT_W-1:0] cnt;
    logic [NR-1:0]                  phase;
  } dsil_flash_t;

  dsil_flash_t s;
  dsil_flash_t next_s;

  always_comb begin
    next_s = s;
    if (ce) begin
      for (int i = 0; i < NR; i++) begin
        if (s.cnt[i] == HALF[i]) begin // [RULE_16]
          next_s.cnt[i]   = '0;
          next_s.phase[i] = ~s.phase[i];
        end else begin
          next_s.cnt[i] = s.cnt[i] + FLASH_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign slow_phase = s.phase[0];
  assign fast_phase = s.phase[1];

  AST_SLOW_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
    ce && s.cnt[0] == HALF[0] |=> slow_phase != $past(slow_phase)) // [RULE_16]
    else $error("slow flash phase did not toggle at period end");

endmodule

// File: logic/dsil_top.sv
/*
 Drive status indicator encoder: fault, module, network and per-port
 link lamps from supervisor, axis and network state, plus the forced
 safe state on an idle run flag, with an APB register slave.
 Assumes supervisor and axis codes, run flag and mode-change pulse
 come from logic on clk; link and traffic levels come from PHY pins.
*/
// The implementer's own choices: the APB register port and the register offsets.
// Notes on behaviour
// RULE_01: Highest-precedence state picks the lamp pattern; lower ones are ignored.
// RULE_02: Network lamp is off while no network address is configured.
// RULE_03: Network lamp flashes green with an address but no connection.
// RULE_04: Network lamp is steady green while online with a connection.
// RULE_05: Network lamp flashes red when an exclusive-owner connection timed out.
// RULE_06: Network lamp is steady red when our address is used elsewhere.
// RULE_07: During power-up self-test the network lamp alternates green/red slowly.
// RULE_08: After an identifier proposal, alternate fast until a commit succeeds.
// RULE_09: A port link lamp is off while that port has no link.
// RULE_10: A port link lamp is steady green with link and no traffic.
// RULE_11: A port link lamp flashes green with link and traffic.
// RULE_12: Out-of-box supervisor state flashes module lamp green, permits operation.
// RULE_13: Idle run flag while executing forces the drive to safe state.
// RULE_14: Mode change with torque permitted in that condition permits operation again.
// RULE_15: Fault lamp red on axis abort or major fault, supervisor abort or critical.
// RULE_16: Slow and fast flash rates come from parameterised free-running counters.
// RULE_17: Module lamp steady green executing with axis active, flashing red on fault; the code shows steady red on axis abort and supervisor critical.
`timescale 1ns/10ps
module dsil_top
  import dsil_pkg::*;
#(
  parameter int NPORTS    = NPORTS_DEF,
  parameter int SLOW_HALF = SLOW_HALF_CYC,
  parameter int FAST_HALF = FAST_HALF_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [CODE_W-1:0] sup_state,
  input  wire logic [CODE_W-1:0] axis_state,
  input  wire logic              run_flag,
  input  wire logic              mode_chg_torque,
  input  wire logic [NPORTS-1:0] link_up,
  input  wire logic [NPORTS-1:0] link_tx,
  output logic                   fault_red,
  output logic                   module_green,
  output logic                   module_red,
  output logic                   net_green,
  output logic                   net_red,
  output logic      [NPORTS-1:0] link_green,
  output logic                   safe_state,
  output logic                   drive_permit
);

  typedef struct packed {
    logic [NPORTS-1:0] link_s1;
    logic [NPORTS-1:0] link_s2;
    logic [NPORTS-1:0] tx_s1;
    logic [NPORTS-1:0] tx_s2;
    logic [NC_W-1:0]   net_ctrl;
    logic              ident_pending;
    logic              torque_ovr;
    logic              fault_red;
    logic              mod_g;
    logic              mod_r;
    logic              net_g;
    logic              net_r;
    logic [NPORTS-1:0] link_g;
    logic              safe;
    logic              permit;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } dsil_state_t;

  dsil_state_t s;
  dsil_state_t next_s;
  logic        slow_phase;
  logic        fast_phase;

  dsil_flash #(
    .SLOW_HALF (SLOW_HALF),
    .FAST_HALF (FAST_HALF)
  ) u_flash (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .slow_phase (slow_phase),
    .fast_phase (fast_phase)
  );

  function automatic logic [1:0] lamp_gr(input dsil_pat_t p,
                                         input logic slow,
                                         input logic fast);
    unique case (p)
      PAT_OFF:      lamp_gr = 2'h0;
      PAT_GREEN:    lamp_gr = 2'h2;
      PAT_RED:      lamp_gr = 2'h1;
      PAT_FLASH_G:  lamp_gr = {slow, 1'b0};
      PAT_FLASH_R:  lamp_gr = {1'b0, slow};
      PAT_ALT_SLOW: lamp_gr = {slow, ~slow};
      PAT_ALT_FAST: lamp_gr = {fast, ~fast};
      default:      lamp_gr = 2'h0;
    endcase
  endfunction

  function automatic logic is_exec(input logic [CODE_W-1:0] st);
    is_exec = (st == SUP_EXEC) || (st == SUP_EXEC_TRQ);
  endfunction

  function automatic logic ax_active(input logic [CODE_W-1:0] st);
    ax_active = (st == AX_STOPPED) || (st == AX_STOPPING) ||
                (st == AX_STARTING) || (st == AX_RUNNING) ||
                (st == AX_TESTING);
  endfunction

  function automatic logic is_fault(input logic [CODE_W-1:0] sup,
                                    input logic [CODE_W-1:0] ax);
    is_fault = (ax == AX_ABORTING) || (ax == AX_MAJOR_FLT) ||
               (sup == SUP_ABORT) || (sup == SUP_CRIT);
  endfunction

  logic      apb_go;
  logic      forced;
  logic      ovr;
  dsil_pat_t mod_pat;
  dsil_pat_t net_pat;
  logic [31:0] status_word;

  assign apb_go = psel && penable && !s.pready;
  assign forced = is_exec(sup_state) && !run_flag;
  assign status_word = 32'({s.ident_pending, s.permit, s.safe, s.link_g,
                            s.net_r, s.net_g, s.mod_r, s.mod_g,
                            s.fault_red});

  // The mode-change pulse only counts while the drive is held safe.
  always_comb begin
    ovr = forced && (s.torque_ovr || mode_chg_torque); // [RULE_14]
  end

  // Precedence runs from the top of each chain downward.
  always_comb begin
    if (sup_state == SUP_CRIT || sup_state == SUP_TEST_EXC) begin
      mod_pat = PAT_RED; // [RULE_01]
    end else if (sup_state == SUP_ABORT || axis_state == AX_MAJOR_FLT) begin
      mod_pat = PAT_FLASH_R; // [RULE_17]
    end else if (axis_state == AX_ABORTING) begin
      mod_pat = PAT_RED;
    end else if (sup_state == SUP_SELF_TEST ||
                 axis_state == AX_SELF_TEST ||
                 sup_state == SUP_WAIT_ID || sup_state == SUP_CONFIG) begin
      mod_pat = PAT_ALT_SLOW;
    end else if (sup_state == SUP_IDLE ||
                 sup_state == SUP_WAIT_ID_TRQ) begin
      mod_pat = PAT_FLASH_G; // [RULE_12]
    end else if (is_exec(sup_state) && ax_active(axis_state)) begin
      mod_pat = PAT_GREEN; // [RULE_17]
    end else begin
      mod_pat = PAT_OFF;
    end
  end

  // Self-test comes first: no address exists yet during power-up.
  always_comb begin
    if (s.net_ctrl[NC_SELFTEST]) begin
      net_pat = PAT_ALT_SLOW; // [RULE_07]
    end else if (!s.net_ctrl[NC_ADDR_CFG]) begin
      net_pat = PAT_OFF; // [RULE_02]
    end else if (s.ident_pending) begin
      net_pat = PAT_ALT_FAST; // [RULE_08]
    end else if (s.net_ctrl[NC_CONFLICT]) begin
      net_pat = PAT_RED; // [RULE_06]
    end else if (s.net_ctrl[NC_OWNER_TO]) begin
      net_pat = PAT_FLASH_R; // [RULE_05]
    end else if (s.net_ctrl[NC_CONN]) begin
      net_pat = PAT_GREEN; // [RULE_04]
    end else begin
      net_pat = PAT_FLASH_G; // [RULE_03]
    end
  end

  always_comb begin
    next_s = s;
    // The bus answer is a pulse, so it drops even while frozen.
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    if (ce) begin
      next_s.link_s1 = link_up;
      next_s.link_s2 = s.link_s1;
      next_s.tx_s1   = link_tx;
      next_s.tx_s2   = s.tx_s1;
      if (apb_go) begin
        next_s.pready = 1'b1;
        next_s.prdata = '0;
        unique case (paddr)
          NET_CTRL_ADDR: begin
            if (pwrite) begin
              next_s.net_ctrl = pwdata[NC_W-1:0];
            end
            next_s.prdata = 32'(s.net_ctrl);
          end
          ID_CMD_ADDR: begin
            // A proposal in the same write as a commit wins.
            if (pwrite && pwdata[ID_COMMIT]) begin
              next_s.ident_pending = 1'b0;
            end
            if (pwrite && pwdata[ID_PROPOSE]) begin
              next_s.ident_pending = 1'b1; // [RULE_08]
            end
          end
          STATUS_ADDR: begin
            next_s.prdata = status_word;
          end
          default: begin
            next_s.pslverr = 1'b1;
          end
        endcase
      end
      next_s.torque_ovr = ovr;
      next_s.safe   = forced && !ovr; // [RULE_13]
      next_s.permit = (sup_state == SUP_WAIT_ID_TRQ) ||
                      (is_exec(sup_state) && !(forced && !ovr)); // [RULE_12]
      next_s.fault_red = is_fault(sup_state, axis_state); // [RULE_15]
      {next_s.mod_g, next_s.mod_r} = lamp_gr(mod_pat, slow_phase,
                                             fast_phase);
      {next_s.net_g, next_s.net_r} = lamp_gr(net_pat, slow_phase,
                                             fast_phase);
      for (int i = 0; i < NPORTS; i++) begin
        next_s.link_g[i] = s.link_s2[i] && // [RULE_10]
                           (!s.tx_s2[i] || fast_phase); // [RULE_09] [RULE_11]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.net_ctrl <= NC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata       = s.prdata;
  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign fault_red    = s.fault_red;
  assign module_green = s.mod_g;
  assign module_red   = s.mod_r;
  assign net_green    = s.net_g;
  assign net_red      = s.net_r;
  assign link_green   = s.link_g;
  assign safe_state   = s.safe;
  assign drive_permit = s.permit;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic flt_in;
  logic net_base;
  assign flt_in   = is_fault(sup_state, axis_state);
  assign net_base = ce && !s.net_ctrl[NC_SELFTEST] &&
                    s.net_ctrl[NC_ADDR_CFG] && !s.ident_pending;

  AST_CRIT_WINS: assert property (ce && sup_state == SUP_CRIT // [RULE_01]
    |=> module_red && !module_green && fault_red)
    else $error("critical fault did not win module lamp");
  AST_NET_OFF: assert property (ce && !s.net_ctrl[NC_SELFTEST] && // [RULE_02]
    !s.net_ctrl[NC_ADDR_CFG] |=> !net_green && !net_red)
    else $error("network lamp lit without an address");
  AST_NET_FLASH_G: assert property (net_base && s.net_ctrl == // [RULE_03]
    NC_W'(1 << NC_ADDR_CFG) |=> net_green == $past(slow_phase) && !net_red)
    else $error("network lamp not flashing green");
  AST_NET_GREEN: assert property (net_base && !s.net_ctrl[NC_CONFLICT] // [RULE_04]
    && !s.net_ctrl[NC_OWNER_TO] && s.net_ctrl[NC_CONN]
    |=> net_green && !net_red)
    else $error("network lamp not steady green");
  AST_NET_FLASH_R: assert property (net_base && // [RULE_05]
    !s.net_ctrl[NC_CONFLICT] && s.net_ctrl[NC_OWNER_TO]
    |=> net_red == $past(slow_phase) && !net_green)
    else $error("network lamp not flashing red");
  AST_NET_RED: assert property (net_base && s.net_ctrl[NC_CONFLICT] // [RULE_06]
    |=> net_red && !net_green)
    else $error("network lamp not steady red on conflict");
  AST_NET_SELFTEST: assert property (ce && s.net_ctrl[NC_SELFTEST] // [RULE_07]
    |=> net_green == $past(slow_phase) && net_red != net_green)
    else $error("network lamp not alternating slowly");
  AST_IDENT: assert property (ce && apb_go && pwrite && // [RULE_08]
    paddr == ID_CMD_ADDR && pwdata[ID_PROPOSE] ##1 ce && !$rose(s.net_ctrl[0])
    && s.net_ctrl[NC_ADDR_CFG] && !s.net_ctrl[NC_SELFTEST]
    |=> net_green == $past(fast_phase) && net_red != net_green)
    else $error("network lamp not alternating fast after proposal");
  AST_LINK_OFF: assert property (ce && !s.link_s2[0] // [RULE_09]
    |=> !link_green[0])
    else $error("link lamp lit without link");
  AST_LINK_STEADY: assert property (ce && s.link_s2[0] && !s.tx_s2[0] // [RULE_10]
    |=> link_green[0])
    else $error("link lamp not steady green");
  AST_LINK_FLASH: assert property (ce && s.link_s2[0] && s.tx_s2[0] // [RULE_11]
    |=> link_green[0] == $past(fast_phase))
    else $error("link lamp not flashing with traffic");
  AST_OOB: assert property (ce && sup_state == SUP_WAIT_ID_TRQ && // [RULE_12]
    !flt_in && axis_state != AX_SELF_TEST
    |=> drive_permit && module_green == $past(slow_phase) && !module_red)
    else $error("out-of-box state not flashing green with torque");
  AST_SAFE: assert property (ce && forced && !s.torque_ovr && // [RULE_13]
    !mode_chg_torque |=> safe_state && !drive_permit)
    else $error("idle run flag did not force safe state");
  AST_OVERRIDE: assert property (ce && forced && mode_chg_torque // [RULE_14]
    ##1 ce && forced |=> !safe_state && drive_permit)
    else $error("mode change did not permit operation");
  AST_FAULT: assert property (ce |=> fault_red == $past(flt_in)) // [RULE_15]
    else $error("fault lamp does not follow fault states");
  AST_MOD_GREEN: assert property (ce && is_exec(sup_state) && // [RULE_17]
    ax_active(axis_state) |=> module_green && !module_red)
    else $error("module lamp not steady green while executing");
  AST_MOD_FLASH_R: assert property (ce && axis_state == AX_MAJOR_FLT && // [RULE_17]
    sup_state != SUP_CRIT && sup_state != SUP_TEST_EXC
    |=> module_red == $past(slow_phase) && !module_green)
    else $error("module lamp not flashing red on major fault");

  COV_SAFE: cover property (ce && forced ##1 safe_state);
  COV_OVR: cover property (safe_state ##1 ce && mode_chg_torque
    ##1 drive_permit);
  COV_IDENT: cover property (s.ident_pending ##1 !s.ident_pending);
  COV_APB_ERR: cover property (pready && pslverr);

endmodule

// File: dv/dsil_lamp_view.sv
/*
 Operator's view of one bicolour lamp: counts what the lamp showed
 over a window and names the pattern that an observer would report.
 Assumes the window is started by clr and lasts four slow half
 periods, so a slow alternation toggles about four times and a fast
 one about eight.
*/
`timescale 1ns/10ps
module dsil_lamp_view
  import dsil_pkg::*;
(
  input  wire logic clk,
  input  wire logic clr,
  input  wire logic green,
  input  wire logic red,
  output dsil_pat_t pat
);
  // Four-state counters, so an unknown lamp never reads as a pattern.
  integer n;
  integer ng;
  integer nr;
  integer tg;
  logic   pg;

  always @(posedge clk) begin
    if (clr) begin
      n <= 0;
      ng <= 0;
      nr <= 0;
      tg <= 0;
    end else begin
      n <= n + 1;
      ng <= ng + green;
      nr <= nr + red;
      tg <= tg + (green != pg);
    end
    pg <= green;
  end

  always_comb begin
    pat = dsil_pat_t'(3'bxxx);
    if (ng == 0 && nr == 0) pat = PAT_OFF;
    else if (ng == n && nr == 0) pat = PAT_GREEN;
    else if (nr == n && ng == 0) pat = PAT_RED;
    else if (nr == 0 && ng > 0) pat = PAT_FLASH_G;
    else if (ng == 0 && nr > 0) pat = PAT_FLASH_R;
    else if (ng > 0 && nr > 0) pat = (tg > 5) ? PAT_ALT_FAST : PAT_ALT_SLOW;
  end
endmodule

// File: dv/test_drive_status_indicator_logic.sv
/*
 Self-checking bench for the status indicator encoder: network lamp
 through its register, module and fault lamps over every state code,
 link lamps, and the forced safe state with its override.
 Assumes short flash half periods so a lamp window stays brief.
*/
`timescale 1ns/10ps
module test_drive_status_indicator_logic
  import dsil_pkg::*;
;
  localparam int SH = 8;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        run_flag, mode_chg_torque, clr, fault_red, module_green;
  logic        module_red, net_green, net_red, safe_state, drive_permit;
  logic        err, pend, ce;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  sup_state, axis_state;
  logic [1:0]  link_up, link_tx, link_green;
  dsil_pat_t   p_net, p_mod, p_flt, p_l0, p_l1;
  int          error_cnt, cmp_count, v;

  always #2 clk = ~clk;

  dsil_top #(.NPORTS(2), .SLOW_HALF(SH), .FAST_HALF(SH / 2)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sup_state(sup_state), .axis_state(axis_state),
    .run_flag(run_flag), .mode_chg_torque(mode_chg_torque),
    .link_up(link_up), .link_tx(link_tx), .fault_red(fault_red),
    .module_green(module_green), .module_red(module_red),
    .net_green(net_green), .net_red(net_red), .link_green(link_green),
    .safe_state(safe_state), .drive_permit(drive_permit));

  dsil_lamp_view v_net (.clk(clk), .clr(clr), .green(net_green),
    .red(net_red), .pat(p_net));
  dsil_lamp_view v_mod (.clk(clk), .clr(clr), .green(module_green),
    .red(module_red), .pat(p_mod));
  dsil_lamp_view v_flt (.clk(clk), .clr(clr), .green(1'b0),
    .red(fault_red), .pat(p_flt));
  dsil_lamp_view v_l0 (.clk(clk), .clr(clr), .green(link_green[0]),
    .red(1'b0), .pat(p_l0));
  dsil_lamp_view v_l1 (.clk(clk), .clr(clr), .green(link_green[1]),
    .red(1'b0), .pat(p_l1));

  task automatic cmp_pat(input string s, input dsil_pat_t x,
                         input dsil_pat_t g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s exp=%0d got=%0d", s, x, g);
    end
  endtask

  task automatic cmp_val(input string s, input logic [31:0] x,
                         input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %s exp=%h got=%h", s, x, g);
    end
  endtask

  task conclude;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The request is held until pready is seen high at a rising edge; only
  // the watchdog ends a wait, and the slave answers after one wait state.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    cmp_val("apb wait", 32'h2, 32'(n));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task look;
    repeat (4) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (4 * SH) @(posedge clk);
  endtask

  function automatic dsil_pat_t net_exp(input logic [4:0] n, input logic p);
    if (n[NC_SELFTEST]) return PAT_ALT_SLOW;
    if (!n[NC_ADDR_CFG]) return PAT_OFF;
    if (p) return PAT_ALT_FAST;
    if (n[NC_CONFLICT]) return PAT_RED;
    if (n[NC_OWNER_TO]) return PAT_FLASH_R;
    if (n[NC_CONN]) return PAT_GREEN;
    return PAT_FLASH_G;
  endfunction

  function automatic dsil_pat_t mod_exp(input logic [3:0] s,
                                        input logic [3:0] a);
    if (s == SUP_CRIT || s == SUP_TEST_EXC) return PAT_RED;
    if (s == SUP_ABORT || a == AX_MAJOR_FLT) return PAT_FLASH_R;
    if (a == AX_ABORTING) return PAT_RED;
    if (s inside {SUP_SELF_TEST, SUP_WAIT_ID, SUP_CONFIG}) return PAT_ALT_SLOW;
    if (a == AX_SELF_TEST) return PAT_ALT_SLOW;
    if (s == SUP_IDLE || s == SUP_WAIT_ID_TRQ) return PAT_FLASH_G;
    if (s inside {SUP_EXEC, SUP_EXEC_TRQ} && a inside {[AX_STOPPED:AX_TESTING]})
      return PAT_GREEN;
    return PAT_OFF;
  endfunction

  function automatic dsil_pat_t link_exp(input logic u, input logic t);
    return !u ? PAT_OFF : (t ? PAT_FLASH_G : PAT_GREEN);
  endfunction

  task automatic net_step(input logic [4:0] n, input logic [1:0] cmd);
    apb(1'b1, NET_CTRL_ADDR, {27'h0, n});
    apb(1'b1, ID_CMD_ADDR, {30'h0, cmd});
    if (cmd[ID_PROPOSE]) pend = 1'b1;
    else if (cmd[ID_COMMIT]) pend = 1'b0;
    look;
    cmp_pat("net lamp", net_exp(n, pend), p_net);
    apb(1'b0, NET_CTRL_ADDR, 32'h0);
    cmp_val("net_ctrl", {27'h0, n}, rd);
    apb(1'b0, STATUS_ADDR, 32'h0);
    cmp_val("pending", {31'h0, pend}, {31'h0, rd[9]});
  endtask

  task automatic mod_step(input logic [3:0] s, input logic [3:0] a);
    sup_state <= s;
    axis_state <= a;
    look;
    cmp_pat("module lamp", mod_exp(s, a), p_mod);
    cmp_pat("fault lamp", (a == AX_ABORTING || a == AX_MAJOR_FLT ||
      s == SUP_ABORT || s == SUP_CRIT) ? PAT_RED : PAT_OFF, p_flt);
  endtask

  task automatic sp(input logic s, input logic p);
    repeat (3) @(posedge clk);
    cmp_val("safe,permit", {30'h0, s, p}, {30'h0, safe_state, drive_permit});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude;
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, mode_chg_torque, clr, pend} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    sup_state = SUP_IDLE;
    axis_state = AX_INIT;
    run_flag = 1'b1;
    ce = 1'b1;
    link_up = 2'h0;
    link_tx = 2'h0;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(69909));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    look;
    cmp_pat("net lamp reset", PAT_ALT_SLOW, p_net);
    // A frozen block must hold its alternating lamp across several halves.
    ce <= 1'b0;
    @(posedge clk);
    rd = {30'h0, net_green, net_red};
    repeat (3 * SH) @(posedge clk);
    cmp_val("frozen lamp", rd, {30'h0, net_green, net_red});
    ce <= 1'b1;
    apb(1'b0, NET_CTRL_ADDR, 32'h0);
    cmp_val("net_ctrl reset", {27'h0, NC_RESET}, rd);
    apb(1'b0, 8'h0c, 32'h0);
    cmp_val("unmapped", 32'h1, {31'h0, err});
    cmp_val("unmapped data", 32'h0, rd);
    apb(1'b0, ID_CMD_ADDR, 32'h0);
    cmp_val("id_cmd read", 32'h0, rd);
    net_step(5'h00, 2'h0);
    net_step(5'h01, 2'h0);
    net_step(5'h03, 2'h0);
    net_step(5'h07, 2'h0);
    net_step(5'h0f, 2'h0);
    net_step(5'h0e, 2'h0);
    net_step(5'h0f, 2'h1);
    net_step(5'h0f, 2'h3);
    net_step(5'h1f, 2'h0);
    net_step(5'h0f, 2'h2);
    repeat (6) net_step(5'($urandom % 32), 2'($urandom % 4));
    for (v = 0; v < 10; v++) mod_step(4'(v), 4'($urandom % 12));
    for (v = 0; v < 12; v++) mod_step(4'($urandom % 10), 4'(v));
    for (v = 0; v < 8; v++) begin
      link_up <= (v == 0) ? 2'h1 : 2'($urandom % 4);
      link_tx <= (v == 0) ? 2'h3 : 2'($urandom % 4);
      look;
      cmp_pat("link 0", link_exp(link_up[0], link_tx[0]), p_l0);
      cmp_pat("link 1", link_exp(link_up[1], link_tx[1]), p_l1);
    end
    sup_state <= SUP_EXEC;
    axis_state <= AX_RUNNING;
    sp(1'b0, 1'b1);
    run_flag <= 1'b0;
    sp(1'b1, 1'b0);
    mode_chg_torque <= 1'b1;
    @(posedge clk);
    mode_chg_torque <= 1'b0;
    sp(1'b0, 1'b1);
    run_flag <= 1'b1;
    sp(1'b0, 1'b1);
    run_flag <= 1'b0;
    sp(1'b1, 1'b0);
    sup_state <= SUP_WAIT_ID_TRQ;
    sp(1'b0, 1'b1);
    conclude;
  end
endmodule
